// ==== hdl/timer_x_channel.sv ====
// One timer X channel: interval timer, event counter and one-shot modes
module timer_x_channel (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic subclockDiv32,
   input wire logic timerBUnit1Ovf,
   input wire logic timerAUnit0Ovf,
   input wire logic timerXOtherOvf,
   input wire logic pinIn,
   output logic pinOut,
   output logic pinOe,
   output logic irqReq
);
   logic [12:0] mode_reg;
   logic [15:0] reload_reg;
   logic [15:0] counter_reg;
   logic [15:0] counter_next;
   logic startFlag_reg;
   logic osActive_reg;
   logic pinPrev_reg;
   logic [4:0] prescale_reg;
   logic toggle_reg;
   logic pinOe_reg;
   logic irq_reg;
   logic ack_reg;
   logic [31:0] rdData_reg;
   logic wrFire;
   logic wrCount;
   logic wrMode;
   logic wrStart;
   logic [15:0] newCount;
   logic [12:0] newMode;
   logic startNow;
   timer_x_pkg::opMode_t opMode;
   logic isTimer;
   logic isEvent;
   logic isOneShot;
   logic clkTick;
   logic pinRise;
   logic pinFall;
   logic pinEdge;
   logic ovfTick;
   logic evTick;
   logic gateOk;
   logic runTE;
   logic tick;
   logic underflow;
   logic expiry;
   logic trigEdge;
   logic osTrig;
   logic halted;
   logic [31:0] rdValue;
   logic [31:0] wrMask;

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   generate
      for (genvar b = 0; b < 4; b++) begin : gLane
         assign wrMask[8*b+7:8*b] = {8{sel_i[b]}};
      end
   endgenerate

   assign wrFire = cyc_i & stb_i & we_i & ack_reg;
   assign wrMode = wrFire & (adr_i == timer_x_pkg::MODE_OFS);
   assign wrCount = wrFire & (adr_i == timer_x_pkg::COUNT_OFS);
   assign wrStart = wrFire & (adr_i == timer_x_pkg::START_OFS) & sel_i[0];
   assign newCount = (reload_reg & ~wrMask[15:0]) | (dat_i[15:0] & wrMask[15:0]);
   assign newMode = (mode_reg & ~wrMask[12:0]) | (dat_i[12:0] & wrMask[12:0]);

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= cyc_i & stb_i & ~ack_reg;
      end
   end

   always_comb begin
      rdValue = 32'h0000_0000;
      case (adr_i)
         timer_x_pkg::MODE_OFS: rdValue[12:0] = mode_reg;
         timer_x_pkg::COUNT_OFS: begin
            if (isOneShot) begin
               rdValue[15:0] = timer_x_pkg::ONESHOT_READ;
            end else begin
               rdValue[15:0] = counter_reg;
            end
         end
         timer_x_pkg::START_OFS: rdValue[0] = startFlag_reg;
         timer_x_pkg::STATUS_OFS: rdValue[2:0] = {pinIn, toggle_reg, ~halted};
         default: rdValue = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdData_reg <= 32'h0000_0000;
      end else if (cyc_i & stb_i & ~ack_reg & ~we_i) begin
         rdData_reg <= rdValue;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         mode_reg <= timer_x_pkg::MODE_RST;
      end else if (wrMode) begin
         mode_reg <= newMode;
      end
   end

   assign startNow = wrStart ? dat_i[timer_x_pkg::CNT_START_BIT] : startFlag_reg;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         startFlag_reg <= 1'b0;
      end else begin
         startFlag_reg <= startNow;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         reload_reg <= timer_x_pkg::COUNT_RST;
      end else if (wrCount) begin
         reload_reg <= newCount;
      end
   end

   // ----------------------------------------
   // Count sources
   // ----------------------------------------
   assign opMode = timer_x_pkg::opMode_t'(mode_reg[timer_x_pkg::MODE_LSB +: 2]);
   assign isTimer = (opMode == timer_x_pkg::MODE_TIMER);
   assign isEvent = (opMode == timer_x_pkg::MODE_EVENT);
   assign isOneShot = (opMode == timer_x_pkg::MODE_ONESHOT);

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         prescale_reg <= timer_x_pkg::PRESCALE_RST;
      end else begin
         prescale_reg <= prescale_reg + 5'h01;
      end
   end

   always_comb begin
      case (mode_reg[timer_x_pkg::CLKSEL_LSB +: 2])
         2'b00: clkTick = 1'b1;
         2'b01: clkTick = (prescale_reg[2:0] == timer_x_pkg::DIV8_LAST);
         2'b10: clkTick = (prescale_reg == timer_x_pkg::DIV32_LAST);
         default: clkTick = subclockDiv32;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pinPrev_reg <= 1'b0;
      end else begin
         pinPrev_reg <= pinIn;
      end
   end

   assign pinRise = pinIn & ~pinPrev_reg;
   assign pinFall = ~pinIn & pinPrev_reg;

   always_comb begin
      case (timer_x_pkg::edgeSel_t'(mode_reg[timer_x_pkg::CLKSEL_LSB +: 2]))
         timer_x_pkg::EDGE_RISE: pinEdge = pinRise;
         timer_x_pkg::EDGE_FALL: pinEdge = pinFall;
         default: pinEdge = pinRise | pinFall;
      endcase
   end

   always_comb begin
      case (mode_reg[timer_x_pkg::EVSRC_LSB +: 2])
         2'b01: ovfTick = timerBUnit1Ovf;
         2'b10: ovfTick = timerAUnit0Ovf;
         2'b11: ovfTick = timerXOtherOvf;
         default: ovfTick = 1'b0;
      endcase
   end

   assign evTick = (mode_reg[timer_x_pkg::EVSRC_LSB +: 2] == 2'b00) ? pinEdge : ovfTick;
   assign gateOk = ~mode_reg[timer_x_pkg::GATE_EN_BIT] |
      (pinIn == mode_reg[timer_x_pkg::GATE_LVL_BIT]);
   assign runTE = startFlag_reg & ((isTimer & gateOk) | isEvent);
   assign tick = isOneShot ? (osActive_reg & clkTick) :
      (runTE & (isTimer ? clkTick : evTick));
   assign underflow = tick & (isTimer | isEvent) & (counter_reg == 16'h0000);
   assign expiry = tick & isOneShot & (counter_reg <= 16'h0001);
   assign halted = isOneShot ? ~osActive_reg : ~startFlag_reg;

   // ----------------------------------------
   // One-shot trigger
   // ----------------------------------------
   assign trigEdge = mode_reg[timer_x_pkg::TRIG_EDGE_BIT] ? pinFall : pinRise;

   always_comb begin
      osTrig = wrStart & dat_i[timer_x_pkg::OS_START_BIT];
      case (timer_x_pkg::trigSel_t'(mode_reg[timer_x_pkg::TRIGSEL_LSB +: 2]))
         timer_x_pkg::TRIG_PIN: osTrig = osTrig | trigEdge;
         timer_x_pkg::TRIG_OVF: osTrig = osTrig | ovfTick;
         timer_x_pkg::TRIG_ANY: osTrig = osTrig | trigEdge | ovfTick;
         default: osTrig = osTrig;
      endcase
      osTrig = osTrig & isOneShot & startNow;
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         osActive_reg <= 1'b0;
      end else if (!isOneShot || !startNow) begin
         osActive_reg <= 1'b0;
      end else if (osTrig) begin
         osActive_reg <= 1'b1;
      end else if (expiry) begin
         osActive_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always_comb begin
      counter_next = counter_reg;
      if (wrCount && halted) begin
         counter_next = newCount;
      end else if (osTrig) begin
         counter_next = reload_reg;
      end else if (expiry) begin
         counter_next = reload_reg;
      end else if (underflow) begin
         if (isEvent && mode_reg[timer_x_pkg::FREERUN_BIT]) begin
            counter_next = 16'hFFFF;
         end else begin
            counter_next = reload_reg;
         end
      end else if (tick) begin
         counter_next = counter_reg - 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         counter_reg <= timer_x_pkg::COUNT_RST;
      end else begin
         counter_reg <= counter_next;
      end
   end

   // ----------------------------------------
   // Interrupt request and pin
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= underflow | expiry;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         toggle_reg <= 1'b0;
      end else if (!mode_reg[timer_x_pkg::PULSE_BIT]) begin
         toggle_reg <= 1'b0;
      end else if (underflow || expiry) begin
         toggle_reg <= ~toggle_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pinOe_reg <= 1'b0;
      end else begin
         pinOe_reg <= mode_reg[timer_x_pkg::PULSE_BIT] &
            (opMode != timer_x_pkg::MODE_OFF);
      end
   end

   assign dat_o = rdData_reg;
   assign ack_o = ack_reg;
   assign irqReq = irq_reg;
   assign pinOut = toggle_reg;
   assign pinOe = pinOe_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   mode_select_a:
   assert property (wrMode && sel_i[0] |=> mode_reg[1:0] == $past(dat_i[1:0]))
      else $error("mode write not applied");

   ack_pulse_a:
   assert property (ack_reg |=> !ack_reg)
      else $error("ack held more than one cycle");

   underflow_reload_a:
   assert property (underflow && !(wrCount && halted) && !mode_reg[8] |=>
      counter_reg == $past(reload_reg))
      else $error("no reload on underflow");

   underflow_irq_a:
   assert property (underflow |=> irq_reg)
      else $error("underflow without interrupt");

   halted_write_a:
   assert property (wrCount && halted |=> counter_reg == reload_reg)
      else $error("halted write missed counter");

   stop_holds_a:
   assert property (!startFlag_reg && !isOneShot && !wrCount |=> $stable(counter_reg))
      else $error("counter moved while stopped");

   pulse_toggle_a:
   assert property (irq_reg && pinOe_reg && $past(mode_reg[2]) && mode_reg[2] |->
      toggle_reg != $past(toggle_reg))
      else $error("pin not toggled at underflow");

   oneshot_end_a:
   assert property (expiry && !osTrig |=> !osActive_reg)
      else $error("one-shot did not stop");

   flag_clear_a:
   assert property (isOneShot && wrStart && !dat_i[0] |=> !osActive_reg)
      else $error("one-shot kept running after clear");

   freerun_wrap_a:
   assert property (underflow && isEvent && mode_reg[8] && !(wrCount && halted) |=>
      counter_reg == 16'hFFFF)
      else $error("free-run reloaded");

   oneshot_irq_a:
   assert property (expiry |=> irq_reg)
      else $error("one-shot end without interrupt");
endmodule

// ==== hdl/timer_x_pkg.sv ====
// Constants for one timer X channel with a Wishbone register port
package timer_x_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [3:0] MODE_OFS = 4'h0;
   localparam logic [3:0] COUNT_OFS = 4'h4;
   localparam logic [3:0] START_OFS = 4'h8;
   localparam logic [3:0] STATUS_OFS = 4'hC;
   // ----------------------------------------
   // Mode register fields
   // ----------------------------------------
   localparam int MODE_LSB = 0;
   localparam int PULSE_BIT = 2;
   localparam int GATE_EN_BIT = 3;
   localparam int CLKSEL_LSB = 4;
   localparam int EVSRC_LSB = 6;
   localparam int FREERUN_BIT = 8;
   localparam int GATE_LVL_BIT = 9;
   localparam int TRIG_EDGE_BIT = 10;
   localparam int TRIGSEL_LSB = 11;
   localparam int MODE_W = 13;
   localparam logic [12:0] MODE_RST = 13'h0000;
   // ----------------------------------------
   // Start register fields
   // ----------------------------------------
   localparam int CNT_START_BIT = 0;
   localparam int OS_START_BIT = 1;
   // ----------------------------------------
   // Reset and fixed values
   // ----------------------------------------
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] ONESHOT_READ = 16'h0000;
   localparam logic [4:0] PRESCALE_RST = 5'h00;
   localparam logic [2:0] DIV8_LAST = 3'h7;
   localparam logic [4:0] DIV32_LAST = 5'h1F;
   // ----------------------------------------
   // Enumerations
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_TIMER = 2'b00,
      MODE_EVENT = 2'b01,
      MODE_ONESHOT = 2'b10,
      MODE_OFF = 2'b11
   } opMode_t;
   typedef enum logic [1:0] {
      EDGE_RISE = 2'b00,
      EDGE_FALL = 2'b01,
      EDGE_BOTH = 2'b10,
      EDGE_BOTH2 = 2'b11
   } edgeSel_t;
   typedef enum logic [1:0] {
      TRIG_NONE = 2'b00,
      TRIG_PIN = 2'b01,
      TRIG_OVF = 2'b10,
      TRIG_ANY = 2'b11
   } trigSel_t;
endpackage

// ==== tb/pin_source_model.sv ====
// Signal source, subclock ticks and neighbour timer overflows for the channel
module pin_source_model #(
   parameter int SUB_DIV = 40
) (
   input wire logic mclk,
   input wire logic pinOut,
   input wire logic pinOe,
   output logic pinIn,
   output logic subTick,
   output logic ovfB1,
   output logic ovfA0,
   output logic ovfX
);
   timeunit 1ns;
   timeprecision 1ps;
   logic extLevel = 1'b0;
   int subCnt = 0;
   // Channel output wins while it drives the pin
   assign pinIn = pinOe ? pinOut : extLevel;
   initial begin
      subTick = 1'b0;
      ovfB1 = 1'b0;
      ovfA0 = 1'b0;
      ovfX = 1'b0;
   end
   always @(posedge mclk) begin
      subCnt <= (subCnt == SUB_DIV - 1) ? 0 : subCnt + 1;
      subTick <= (subCnt == SUB_DIV - 1);
   end
   task automatic set_level(input logic lvl);
      @(posedge mclk);
      extLevel <= lvl;
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (3) @(posedge mclk);
         extLevel <= 1'b1;
         repeat (3) @(posedge mclk);
         extLevel <= 1'b0;
      end
      repeat (3) @(posedge mclk);
   endtask
   task automatic ovf(input int which);
      @(posedge mclk);
      ovfB1 <= (which == 1);
      ovfA0 <= (which == 2);
      ovfX <= (which == 3);
      @(posedge mclk);
      ovfB1 <= 1'b0;
      ovfA0 <= 1'b0;
      ovfX <= 1'b0;
      @(posedge mclk);
   endtask
endmodule

// ==== tb/timer_x_interval_event_oneshot_tb_top.sv ====
// Testbench for one timer X channel
module timer_x_interval_event_oneshot_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Signals and monitors
   // ----------------------------------------
   localparam int SUB_DIV = 40;
   localparam logic [3:0] MD = timer_x_pkg::MODE_OFS;
   localparam logic [3:0] CN = timer_x_pkg::COUNT_OFS;
   localparam logic [3:0] ST = timer_x_pkg::START_OFS;
   logic mclk = 1'b0;
   logic rst_b;
   logic cyc;
   logic stb;
   logic we;
   logic [3:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat;
   logic [31:0] rdat, rq;
   logic ack, subTick, ovfB1, ovfA0, ovfX, pinIn, pinOut, pinOe, irqReq;
   int fail_count = 0;
   int num_checks = 0;
   int cycleNum = 0;
   int irqCnt = 0;
   int lastIrq = 0;
   int divs[4] = '{1, 8, 32, SUB_DIV};
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycleNum++;
      if (irqReq === 1'b1) begin
         irqCnt++;
         lastIrq = cycleNum;
      end
   end
   timer_x_channel dut (.mclk(mclk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .subclockDiv32(subTick), .timerBUnit1Ovf(ovfB1), .timerAUnit0Ovf(ovfA0),
      .timerXOtherOvf(ovfX), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irqReq(irqReq));
   pin_source_model #(.SUB_DIV(SUB_DIV)) src (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe),
      .pinIn(pinIn), .subTick(subTick), .ovfB1(ovfB1), .ovfA0(ovfA0), .ovfX(ovfX));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rq = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1) begin
         fail_count++;
         $display("mismatch at %0t: no bus acknowledge", $time);
         wrap_up();
      end
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rq, exp);
   endtask
   task automatic wait_irq(input int bound);
      int c0;
      c0 = irqCnt;
      repeat (bound) begin
         @(posedge mclk);
         #1;
         if (irqCnt != c0) return;
      end
      fail_count++;
      $display("mismatch at %0t: no interrupt request", $time);
      wrap_up();
   endtask
   task automatic period_chk(input int exp);
      int t1;
      wait_irq(exp * 3);
      t1 = lastIrq;
      wait_irq(exp * 3);
      check(32'(lastIrq - t1), 32'(exp));
   endtask
   task automatic setup(input logic [31:0] mode, input logic [31:0] cnt, input logic [31:0] s);
      bus(1'b1, ST, 32'h0);
      bus(1'b1, MD, mode);
      bus(1'b1, CN, cnt);
      bus(1'b1, ST, s);
   endtask
   function automatic logic [31:0] fld(input int v, input int lsb);
      return 32'(v) << lsb;
   endfunction
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int c0;
      int t0;
      rst_b <= 1'b0;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      adr <= 4'h0;
      sel <= 4'hF;
      wdat <= 32'h0000_0000;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      rd_chk(MD, 32'(timer_x_pkg::MODE_RST));
      rd_chk(CN, 32'(timer_x_pkg::COUNT_RST));
      rd_chk(4'h2, 32'h0);
      bus(1'b1, CN, 32'h5);
      rd_chk(CN, 32'h5);
      bus(1'b1, ST, 32'h1);
      period_chk(6);
      bus(1'b1, CN, 32'h9);
      bus(1'b0, CN, 32'h0);
      check(32'(rq <= 32'h5), 32'h1);
      period_chk(10);
      bus(1'b1, ST, 32'h0);
      c0 = irqCnt;
      bus(1'b0, CN, 32'h0);
      repeat (20) @(posedge mclk);
      rd_chk(CN, rq);
      check(32'(irqCnt - c0), 32'h0);
      for (int k = 0; k < 4; k++) begin
         setup(fld(k, timer_x_pkg::CLKSEL_LSB), 32'h1, 32'h1);
         period_chk(2 * divs[k]);
      end
      setup(fld(1, timer_x_pkg::PULSE_BIT), 32'h3, 32'h1);
      wait_irq(20);
      t0 = int'(pinOut);
      check(32'(pinOe), 32'h1);
      wait_irq(20);
      check(32'(pinOut), 32'(t0 == 0));
      src.set_level(1'b0);
      setup(fld(1, timer_x_pkg::GATE_EN_BIT) | fld(1, timer_x_pkg::GATE_LVL_BIT), 32'h3, 32'h1);
      c0 = irqCnt;
      repeat (40) @(posedge mclk);
      check(32'(irqCnt - c0), 32'h0);
      src.set_level(1'b1);
      period_chk(4);
      src.set_level(1'b0);
      for (int k = 0; k < 3; k++) begin
         setup(fld(1, 0) | fld(k, timer_x_pkg::CLKSEL_LSB), 32'h2, 32'h1);
         c0 = irqCnt;
         src.pulses(3);
         check(32'(irqCnt - c0), (k == 2) ? 32'h2 : 32'h1);
      end
      for (int k = 1; k < 4; k++) begin
         setup(fld(1, 0) | fld(k, timer_x_pkg::EVSRC_LSB), 32'h2, 32'h1);
         c0 = irqCnt;
         repeat (3) src.ovf(k);
         repeat (3) @(posedge mclk);
         check(32'(irqCnt - c0), 32'h1);
      end
      setup(fld(1, 0) | fld(1, timer_x_pkg::EVSRC_LSB) | fld(1, timer_x_pkg::FREERUN_BIT),
         32'h0, 32'h1);
      src.ovf(1);
      repeat (3) @(posedge mclk);
      rd_chk(CN, 32'h0000_FFFF);
      c0 = irqCnt;
      setup(fld(2, 0), 32'd20, 32'h3);
      rd_chk(CN, 32'(timer_x_pkg::ONESHOT_READ));
      bus(1'b1, ST, 32'h3);
      t0 = cycleNum;
      repeat (17) @(posedge mclk);
      check(32'(irqCnt - c0), 32'h0);
      wait_irq(30);
      check(32'((lastIrq - t0) inside {[18:24]}), 32'h1);
      repeat (60) @(posedge mclk);
      check(32'(irqCnt - c0), 32'h1);
      setup(fld(2, 0) | fld(1, timer_x_pkg::TRIGSEL_LSB), 32'h8, 32'h1);
      c0 = irqCnt;
      repeat (30) @(posedge mclk);
      check(32'(irqCnt - c0), 32'h0);
      src.pulses(1);
      wait_irq(20);
      setup(fld(2, 0) | fld(1, timer_x_pkg::EVSRC_LSB) | fld(2, timer_x_pkg::TRIGSEL_LSB),
         32'h8, 32'h1);
      src.ovf(1);
      wait_irq(20);
      setup(fld(2, 0), 32'd20, 32'h3);
      c0 = irqCnt;
      bus(1'b1, ST, 32'h0);
      repeat (60) @(posedge mclk);
      check(32'(irqCnt - c0), 32'h0);
      bus(1'b1, MD, 32'h0);
      bus(1'b1, CN, 32'h1234);
      sel <= 4'h2;
      bus(1'b1, CN, 32'h0000_AB99);
      sel <= 4'hF;
      rd_chk(CN, 32'h0000_AB34);
      rd_chk(timer_x_pkg::STATUS_OFS, 32'h0);
      bus(1'b1, ST, 32'h1);
      rd_chk(timer_x_pkg::STATUS_OFS, 32'h1);
      setup(fld(2, 0) | fld(1, timer_x_pkg::TRIG_EDGE_BIT) | fld(3, timer_x_pkg::TRIGSEL_LSB),
         32'h8, 32'h1);
      c0 = irqCnt;
      src.set_level(1'b1);
      repeat (20) @(posedge mclk);
      check(32'(irqCnt - c0), 32'h0);
      src.set_level(1'b0);
      wait_irq(20);
      bus(1'b1, MD, 32'(timer_x_pkg::MODE_OFF) | fld(1, timer_x_pkg::PULSE_BIT));
      repeat (2) @(posedge mclk);
      check(32'(pinOe), 32'h0);
      wrap_up();
   end
endmodule
